// >>> design/ctcr_defines.vh
// Purpose: constants for the converter trim configuration register bank
// Assumes: 8-bit registers reached by an internal command port
// Notes:   all offsets, fields and reset values live here
// Behaviour
// - bit 7 selects automatic(1) or manual(0) offset
// - manual trim bits 6:5 used only when manual
// - bias undervoltage code bits 2:0, top bit gates
// - power-good window select bit 7, resets to one
// - spare stored bit drives internal output
// - bit 4 bypasses tracking-ok switcher enable gate
// - tracking target bits 3:0 reset to all ones
// - host reads and overwrites every writable field
`ifndef CTCR_DEFINES_VH
`define CTCR_DEFINES_VH

// register offsets on the management command port
`define CTCR_ADDR_LOOP_OFFSET  8'hd4
`define CTCR_ADDR_BIAS_UV      8'hd6
`define CTCR_ADDR_PG_TRACK     8'hd7

// writable-bit masks per register
`define CTCR_MASK_LOOP_OFFSET  8'he0
`define CTCR_MASK_BIAS_UV      8'h07
`define CTCR_MASK_PG_TRACK     8'hdf

// reset values
`define CTCR_RST_LOOP_OFFSET   8'h80
`define CTCR_RST_BIAS_UV       8'h00
`define CTCR_RST_PG_TRACK      8'h8f

// field positions
`define CTCR_LO_SCHEME_BIT     7
`define CTCR_LO_TRIM_HI        6
`define CTCR_LO_TRIM_LO        5
`define CTCR_UV_HI             2
`define CTCR_UV_LO             0
`define CTCR_PG_WINDOW_BIT     7
`define CTCR_PG_SPARE_BIT      6
`define CTCR_PG_BYPASS_BIT     4
`define CTCR_PG_TARGET_HI      3
`define CTCR_PG_TARGET_LO      0

// reset values of the decoded setting outputs, matching the register resets
`define CTCR_RST_SCHEME        1'b1
`define CTCR_RST_UV_LEVEL      3'h0
`define CTCR_RST_WINDOW        1'b1
`define CTCR_RST_SPARE         1'b0
`define CTCR_RST_BYPASS        1'b0
`define CTCR_RST_TARGET        4'hf
`define CTCR_RST_ALLOWED       1'b0

// zero constants for gated outputs
`define CTCR_TRIM_ZERO         2'h0
`define CTCR_BYTE_ZERO         8'h00

`endif

// >>> design/ctcr_regs.v
// Purpose: three 8-bit converter trim configuration registers
// Assumes: management bus decoder upstream delivers one-cycle strobes
// Notes:   analog users read the decoded setting outputs
`timescale 1ns/1ps
`include "ctcr_defines.vh"

module ctcr_regs (
	input  wire       ref_clk_i,          // 50 mhz device clock
	input  wire       reset_i,            // synchronous, active high
	input  wire       wr_en_i,            // one-cycle write strobe
	input  wire       rd_en_i,            // one-cycle read strobe
	input  wire [7:0] addr_i,             // register offset
	input  wire [7:0] wdata_i,            // write data
	input  wire       tracking_input_ok_i, // comparator flag from analog pin
	output reg  [7:0] rdata_o,            // read data, one cycle after strobe
	output reg        rvalid_o,           // read data valid pulse
	output reg        loop_offset_scheme_select_o, // 1 automatic, 0 manual
	output reg  [1:0] loop_offset_trim_o,          // applied trim, zero if automatic
	output reg  [2:0] bias_undervoltage_level_o,   // lockout threshold code
	output reg        powergood_window_select_o,   // 1 wide window
	output reg        spare_internal_output_o,     // spare stored bit
	output reg        tracking_gate_bypass_o,      // skip tracking-ok gate
	output reg  [3:0] tracking_final_target_o,     // 50 mv steps from 500 mv
	output reg        switcher_enable_allowed_o    // switcher may start
);

	reg  [7:0] loop_q;    // loop offset register
	reg  [7:0] bias_q;    // bias undervoltage register
	reg  [7:0] pg_q;      // power-good and tracking register
	reg        trk_s1_q;  // synchroniser first stage
	reg        trk_s2_q;  // synchroniser second stage
	reg  [7:0] rd_d;      // read mux

	// analog flag crosses into the clock domain; only s2 is read
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			trk_s1_q <= 1'b0;
			trk_s2_q <= 1'b0;
		end else begin
			trk_s1_q <= tracking_input_ok_i;
			trk_s2_q <= trk_s1_q;
		end
	end

	// register writes; masks keep reserved bits zero
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			loop_q <= `CTCR_RST_LOOP_OFFSET;
			bias_q <= `CTCR_RST_BIAS_UV;
			pg_q   <= `CTCR_RST_PG_TRACK;
		end else if (wr_en_i) begin
			// new value replaces the old setting
			if (addr_i == `CTCR_ADDR_LOOP_OFFSET) begin
				loop_q <= wdata_i & `CTCR_MASK_LOOP_OFFSET;
			end else if (addr_i == `CTCR_ADDR_BIAS_UV) begin
				bias_q <= wdata_i & `CTCR_MASK_BIAS_UV;
			end else if (addr_i == `CTCR_ADDR_PG_TRACK) begin
				pg_q <= wdata_i & `CTCR_MASK_PG_TRACK;
			end
			// unmapped offsets are ignored
		end
	end

	// read decode; unmapped offsets read zero
	always @* begin
		if (addr_i == `CTCR_ADDR_LOOP_OFFSET) begin
			rd_d = loop_q;
		end else if (addr_i == `CTCR_ADDR_BIAS_UV) begin
			rd_d = bias_q;
		end else if (addr_i == `CTCR_ADDR_PG_TRACK) begin
			rd_d = pg_q;
		end else begin
			rd_d = `CTCR_BYTE_ZERO;
		end
	end

	// registered read port and decoded settings; outputs lag storage by one cycle
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			rdata_o                     <= `CTCR_BYTE_ZERO;
			rvalid_o                    <= 1'b0;
			loop_offset_scheme_select_o <= `CTCR_RST_SCHEME;
			loop_offset_trim_o          <= `CTCR_TRIM_ZERO;
			bias_undervoltage_level_o   <= `CTCR_RST_UV_LEVEL;
			powergood_window_select_o   <= `CTCR_RST_WINDOW;
			spare_internal_output_o     <= `CTCR_RST_SPARE;
			tracking_gate_bypass_o      <= `CTCR_RST_BYPASS;
			tracking_final_target_o     <= `CTCR_RST_TARGET;
			switcher_enable_allowed_o   <= `CTCR_RST_ALLOWED;
		end else begin
			rdata_o  <= rd_en_i ? rd_d : `CTCR_BYTE_ZERO;
			rvalid_o <= rd_en_i;
			loop_offset_scheme_select_o <= loop_q[`CTCR_LO_SCHEME_BIT];
			// trim is forced off while the automatic scheme runs
			loop_offset_trim_o <= loop_q[`CTCR_LO_SCHEME_BIT] ? `CTCR_TRIM_ZERO :
				loop_q[`CTCR_LO_TRIM_HI:`CTCR_LO_TRIM_LO];
			// analog side decodes: top bit 0 means the 10.2 v level
			bias_undervoltage_level_o <= bias_q[`CTCR_UV_HI:`CTCR_UV_LO];
			powergood_window_select_o <= pg_q[`CTCR_PG_WINDOW_BIT];
			spare_internal_output_o   <= pg_q[`CTCR_PG_SPARE_BIT];
			tracking_gate_bypass_o    <= pg_q[`CTCR_PG_BYPASS_BIT];
			tracking_final_target_o   <= pg_q[`CTCR_PG_TARGET_HI:`CTCR_PG_TARGET_LO];
			switcher_enable_allowed_o <= pg_q[`CTCR_PG_BYPASS_BIT] | trk_s2_q;
		end
	end

endmodule // ctcr_regs

// >>> verification/ctcr_regs_sva.sv
// Purpose: port assertions for the trim register bank
// Assumes: one clock, sync reset
// Notes:   settings follow a write by two edges
`timescale 1ns/1ps
module ctcr_regs_sva (input logic ref_clk_i, reset_i, wr_en_i, rd_en_i, tracking_input_ok_i, rvalid_o,
	input logic [7:0] addr_i, wdata_i, rdata_o, input logic [1:0] loop_offset_trim_o,
	input logic [2:0] bias_undervoltage_level_o, input logic [3:0] tracking_final_target_o,
	input logic loop_offset_scheme_select_o, powergood_window_select_o, spare_internal_output_o,
	input logic tracking_gate_bypass_o, switcher_enable_allowed_o);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	wire w4 = wr_en_i && addr_i == 8'hd4; // offset write
	wire w7 = wr_en_i && addr_i == 8'hd7; // tracking write
	AST_RV: assert property (rd_en_i |=> rvalid_o) else $error("rv");
	AST_IDLE: assert property (!rd_en_i |=> !rvalid_o && rdata_o == 8'h00) else $error("idle");
	AST_SCH: assert property (w4 |=> ##1 loop_offset_scheme_select_o == $past(wdata_i[7], 2)) else $error("sch");
	AST_TRIM: assert property (w4 && !wdata_i[7] |=> ##1 loop_offset_trim_o == $past(wdata_i[6:5], 2)) else $error("tr");
	AST_AUTO: assert property (loop_offset_scheme_select_o |-> loop_offset_trim_o == 2'h0) else $error("au");
	AST_UV: assert property (wr_en_i && addr_i == 8'hd6 |=> ##1
		bias_undervoltage_level_o == $past(wdata_i[2:0], 2)) else $error("uv");
	AST_PG: assert property (w7 |=> ##1 {powergood_window_select_o, spare_internal_output_o,
		tracking_gate_bypass_o, tracking_final_target_o} == $past({wdata_i[7:6], wdata_i[4:0]}, 2)) else $error("pg");
	AST_GATE: assert property ((!tracking_input_ok_i && !tracking_gate_bypass_o) [*4]
		|-> !switcher_enable_allowed_o) else $error("gate");
endmodule // ctcr_regs_sva
bind ctcr_regs ctcr_regs_sva chk_u (.*);

// >>> verification/testbench.sv
// Purpose: table-driven bench for the trim register bank
// Assumes: strobes driven 1 ns after the edge
// Notes:   unmapped rows read zero
`timescale 1ns/1ps
module testbench;
	logic ref_clk_i = 0, reset_i = 1, wr_en_i = 0, rd_en_i = 0, tracking_input_ok_i = 0, rvalid_o;
	logic [7:0] addr_i = 0, wdata_i = 0, rdata_o;
	logic [1:0] loop_offset_trim_o;
	logic [2:0] bias_undervoltage_level_o;
	logic [3:0] tracking_final_target_o;
	logic loop_offset_scheme_select_o, powergood_window_select_o, spare_internal_output_o;
	logic tracking_gate_bypass_o, switcher_enable_allowed_o;
	int errors = 0, n_tests = 0;
	// offset, write data, readback
	logic [23:0] rows [6] = '{24'hd4_ffe0, 24'hd4_6060, 24'hd6_ff07, 24'hd7_ffdf, 24'hd5_ff00, 24'hd7_0000};
	ctcr_regs dut_u (.*);
	initial forever #10 ref_clk_i = ~ref_clk_i;
	task chk(input string n, input logic [7:0] s, e);
		n_tests++;
		if (s !== e) begin errors++; $display("wrong value %s exp %h got %h", n, e, s); end
	endtask
	// one strobe cycle, write or read
	task acc(input logic w, input logic [7:0] a, d);
		@(posedge ref_clk_i) #1 {wr_en_i, rd_en_i, addr_i, wdata_i} = {w, !w, a, d};
		@(posedge ref_clk_i) #1 {wr_en_i, rd_en_i} = 2'h0;
	endtask
	// reset values of all three registers
	task rchk;
		acc(0, 8'hd4, 0); chk("d4", rdata_o, 8'h80);
		acc(0, 8'hd6, 0); chk("d6", rdata_o, 8'h00);
		acc(0, 8'hd7, 0); chk("d7", rdata_o, 8'h8f);
	endtask
	task summarize;
		$display("errors %0d tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin #50000; errors++; summarize; end
	initial begin
		repeat (12) @(posedge ref_clk_i);
		#1 reset_i = 0;
		rchk;
		foreach (rows[i]) begin
			acc(1, rows[i][23:16], rows[i][15:8]);
			acc(0, rows[i][23:16], 0);
			chk("rdata", rdata_o, rows[i][7:0]);
			chk("rvalid", rvalid_o, 1);
		end
		// decoded settings appear two edges after the write
		acc(1, 8'hd4, 8'h40);
		@(posedge ref_clk_i) #1;
		chk("scheme", loop_offset_scheme_select_o, 0);
		chk("trim", loop_offset_trim_o, 2);
		acc(1, 8'hd4, 8'hc0);
		@(posedge ref_clk_i) #1;
		chk("scheme", loop_offset_scheme_select_o, 1);
		chk("trim", loop_offset_trim_o, 0);
		acc(1, 8'hd6, 8'h05);
		@(posedge ref_clk_i) #1;
		chk("uv", bias_undervoltage_level_o, 5);
		acc(1, 8'hd7, 8'h55);
		@(posedge ref_clk_i) #1;
		chk("window", powergood_window_select_o, 0);
		chk("spare", spare_internal_output_o, 1);
		chk("bypass", tracking_gate_bypass_o, 1);
		chk("target", tracking_final_target_o, 5);
		chk("allow", switcher_enable_allowed_o, 1);
		// reset in mid-run restores defaults
		@(posedge ref_clk_i) #1 reset_i = 1;
		@(posedge ref_clk_i) #1 reset_i = 0;
		rchk;
		chk("window", powergood_window_select_o, 1);
		chk("spare", spare_internal_output_o, 0);
		chk("target", tracking_final_target_o, 4'hf);
		chk("allow", switcher_enable_allowed_o, 0);
		tracking_input_ok_i = 1;
		repeat (4) @(posedge ref_clk_i);
		#1 chk("allow", switcher_enable_allowed_o, 1);
		summarize;
	end
endmodule // testbench
